// File: verilog/can_control_status_init.sv
// CAN control/status register with init, recovery and interrupt gating.
`timescale 1ns/1ps
module can_control_status_init (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_i,
   input  wire can_csr_pkg::cpu_req_t cpu_req_i,
   input  wire can_csr_pkg::core_evt_t core_evt_i,
   input  wire logic                  can_rxd_i,
   output logic [15:0]                cpu_rdata_o,
   output logic                       cpu_ack_o,
   output logic                       bus_join_o,
   output logic                       timing_wr_unlock_o,
   output logic                       test_mode_o,
   output logic                       irq_o
);

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------
   function automatic logic in_window(input logic [15:0] a);
      in_window = (a[15:8] == can_csr_pkg::WIN_PAGE);
   endfunction

   function automatic logic is_csr(input logic [15:0] a);
      is_csr = (a[15:1] == can_csr_pkg::CSR_ADDR[15:1]);
   endfunction

   // ---------------------------------------------------------------
   // Receive pin synchroniser
   // ---------------------------------------------------------------
   logic [2:0] rx_sync_r;
   logic [2:0] rx_sync_nxt;
   logic       rx_level_r;
   logic       rx_level_nxt;

   always_comb
   begin
      rx_sync_nxt  = {rx_sync_r[1:0], can_rxd_i};
      rx_level_nxt = rx_level_r;
      if (rx_sync_r[1] == rx_sync_r[2])
      begin
         rx_level_nxt = rx_sync_r[2];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         rx_sync_r  <= 3'h7;
         rx_level_r <= 1'b1;
      end
      else
      begin
         rx_sync_r  <= rx_sync_nxt;
         rx_level_r <= rx_level_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Register fields
   // ---------------------------------------------------------------
   logic       init_r, ie_r, sie_r, eie_r, cce_r, tst_r;
   logic       init_nxt, ie_nxt, sie_nxt, eie_nxt, cce_nxt, tst_nxt;
   logic [2:0] lec_r, lec_nxt;
   logic       tx_success_flag_r, rx_success_flag_r, bus_off_flag_r, error_warning_flag_r;
   logic       tx_success_flag_nxt, rx_success_flag_nxt, bus_off_flag_nxt, error_warning_flag_nxt;
   logic       irq_nxt;
   logic [15:0] rdata_nxt;
   logic       ack_nxt;
   logic       hit;
   logic       run_done;
   can_csr_pkg::rec_state_t rec_state_r, rec_state_nxt;
   logic [3:0] rec_cnt_r, rec_cnt_nxt;
   logic       join_nxt;

   assign hit = cpu_req_i.wr && is_csr(cpu_req_i.addr);

   // ---------------------------------------------------------------
   // Recovery sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      rec_state_nxt = rec_state_r;
      rec_cnt_nxt   = rec_cnt_r;
      run_done      = 1'b0;
      unique case (rec_state_r)
         can_csr_pkg::REC_HOLD:
         begin
            rec_cnt_nxt = '0;
            if (!init_r)
            begin
               rec_state_nxt = can_csr_pkg::REC_WAIT;
            end
         end
         can_csr_pkg::REC_WAIT:
         begin
            if (init_r)
            begin
               rec_state_nxt = can_csr_pkg::REC_HOLD;
            end
            else if (core_evt_i.bit_tick)
            begin
               if (!rx_level_r)
               begin
                  rec_cnt_nxt = '0;
               end
               else if (rec_cnt_r == can_csr_pkg::RECESSIVE_RUN - 4'h1)
               begin
                  run_done      = 1'b1;
                  rec_cnt_nxt   = '0;
                  rec_state_nxt = can_csr_pkg::REC_RUN;
               end
               else
               begin
                  rec_cnt_nxt = rec_cnt_r + 4'h1;
               end
            end
         end
         can_csr_pkg::REC_RUN:
         begin
            if (init_r)
            begin
               rec_state_nxt = can_csr_pkg::REC_HOLD;
            end
         end
      endcase
      // Join drops one clock after init is set, even with a frame under way.
      join_nxt = (rec_state_nxt == can_csr_pkg::REC_RUN);
   end

   // ---------------------------------------------------------------
   // Register update and interrupt
   // ---------------------------------------------------------------
   always_comb
   begin
      init_nxt = init_r;
      ie_nxt   = ie_r;
      sie_nxt  = sie_r;
      eie_nxt  = eie_r;
      cce_nxt  = cce_r;
      tst_nxt  = tst_r;
      lec_nxt  = lec_r;
      tx_success_flag_nxt = tx_success_flag_r;
      rx_success_flag_nxt = rx_success_flag_r;
      if (hit && cpu_req_i.be[0])
      begin
         init_nxt = cpu_req_i.wdata[can_csr_pkg::INIT_BIT];
         ie_nxt   = cpu_req_i.wdata[can_csr_pkg::IE_BIT];
         sie_nxt  = cpu_req_i.wdata[can_csr_pkg::SIE_BIT];
         eie_nxt  = cpu_req_i.wdata[can_csr_pkg::EIE_BIT];
         cce_nxt  = cpu_req_i.wdata[can_csr_pkg::CCE_BIT];
         tst_nxt  = cpu_req_i.wdata[can_csr_pkg::TST_BIT];
      end
      if (hit && cpu_req_i.be[1])
      begin
         tx_success_flag_nxt = tx_success_flag_r & cpu_req_i.wdata[can_csr_pkg::TX_SUCCESS_FLAG_BIT];
         rx_success_flag_nxt = rx_success_flag_r & cpu_req_i.wdata[can_csr_pkg::RX_SUCCESS_FLAG_BIT];
         if (cpu_req_i.wdata[can_csr_pkg::LEC_LSB +: 3] ==
             can_csr_pkg::LEC_PROBE)
         begin
            lec_nxt = can_csr_pkg::LEC_PROBE;
         end
      end
      // Hardware events come last so that a set beats a host clear.
      if (core_evt_i.tx_ok)
      begin
         tx_success_flag_nxt = 1'b1;
         lec_nxt  = can_csr_pkg::LEC_NONE;
      end
      if (core_evt_i.rx_ok)
      begin
         rx_success_flag_nxt = 1'b1;
         lec_nxt  = can_csr_pkg::LEC_NONE;
      end
      if (core_evt_i.err_valid)
      begin
         lec_nxt = core_evt_i.err_code;
      end
      if (run_done && bus_off_flag_r)
      begin
         lec_nxt = can_csr_pkg::LEC_BIT0;
      end
      bus_off_flag_nxt = core_evt_i.bus_off;
      error_warning_flag_nxt = core_evt_i.err_warn;
      if (core_evt_i.bus_off && !bus_off_flag_r)
      begin
         init_nxt = 1'b1;
      end
      irq_nxt = ie_r &&
                ((sie_r && (core_evt_i.tx_ok || core_evt_i.rx_ok ||
                            core_evt_i.err_valid)) ||
                 (eie_r && ((core_evt_i.bus_off != bus_off_flag_r) ||
                            (core_evt_i.err_warn != error_warning_flag_r))));
      ack_nxt   = (cpu_req_i.rd || cpu_req_i.wr) && in_window(cpu_req_i.addr);
      rdata_nxt = '0;
      if (cpu_req_i.rd && is_csr(cpu_req_i.addr))
      begin
         rdata_nxt = {bus_off_flag_r, error_warning_flag_r, 1'b0, rx_success_flag_r, tx_success_flag_r, lec_r,
                      tst_r, cce_r, 2'b00, eie_r, sie_r, ie_r, init_r};
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         {tst_r, cce_r, eie_r, sie_r, ie_r, init_r} <= '0;
         init_r      <= can_csr_pkg::CTRL_RST[can_csr_pkg::INIT_BIT];
         lec_r       <= can_csr_pkg::LEC_NONE;
         tx_success_flag_r      <= 1'b0;
         rx_success_flag_r      <= 1'b0;
         bus_off_flag_r      <= 1'b0;
         error_warning_flag_r      <= 1'b0;
         irq_o       <= 1'b0;
         cpu_ack_o   <= 1'b0;
         cpu_rdata_o <= '0;
         rec_state_r <= can_csr_pkg::REC_HOLD;
         rec_cnt_r   <= '0;
         bus_join_o  <= 1'b0;
      end
      else
      begin
         init_r      <= init_nxt;
         ie_r        <= ie_nxt;
         sie_r       <= sie_nxt;
         eie_r       <= eie_nxt;
         cce_r       <= cce_nxt;
         tst_r       <= tst_nxt;
         lec_r       <= lec_nxt;
         tx_success_flag_r      <= tx_success_flag_nxt;
         rx_success_flag_r      <= rx_success_flag_nxt;
         bus_off_flag_r      <= bus_off_flag_nxt;
         error_warning_flag_r      <= error_warning_flag_nxt;
         irq_o       <= irq_nxt;
         cpu_ack_o   <= ack_nxt;
         cpu_rdata_o <= rdata_nxt;
         rec_state_r <= rec_state_nxt;
         rec_cnt_r   <= rec_cnt_nxt;
         bus_join_o  <= join_nxt;
      end
   end

   assign timing_wr_unlock_o = cce_r;
   assign test_mode_o        = tst_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_reset_init: assert property ($fell(rst_i) |-> init_r && !ie_r)
      else $error("init not set after reset");
   a_bus_off_init: assert property ($rose(bus_off_flag_r) |-> init_r)
      else $error("bus-off did not set init");
   a_no_join_init: assert property ($past(init_r) |-> !bus_join_o)
      else $error("joined bus while init set");
   a_join_after_run: assert property ($rose(bus_join_o) |->
      $past(rec_cnt_r) == can_csr_pkg::RECESSIVE_RUN - 4'h1)
      else $error("joined before eleven recessive bits");
   a_irq_gate: assert property (irq_o |-> $past(ie_r))
      else $error("interrupt while globally disabled");
   a_status_kept: assert property (!ie_r && core_evt_i.tx_ok |=> tx_success_flag_r &&
      !irq_o)
      else $error("status lost with interrupts off");
   a_status_irq: assert property (ie_r && sie_r && core_evt_i.rx_ok
      |=> irq_o)
      else $error("missing status interrupt");
   a_error_irq: assert property (ie_r && eie_r &&
      (core_evt_i.err_warn != error_warning_flag_r) |=> irq_o)
      else $error("missing error interrupt");
   a_unlock_write: assert property (hit && cpu_req_i.be[0] &&
      cpu_req_i.wdata[can_csr_pkg::CCE_BIT] |=> timing_wr_unlock_o)
      else $error("unlock bit not taken");
   a_lec_clear: assert property (core_evt_i.tx_ok && !core_evt_i.err_valid
      && !run_done |=> lec_r == can_csr_pkg::LEC_NONE)
      else $error("error code not cleared");
   a_tx_success_flag_sticky: assert property (tx_success_flag_r && !(hit && cpu_req_i.be[1])
      |=> tx_success_flag_r)
      else $error("transmit flag cleared by hardware");
   a_byte_lane: assert property (hit && cpu_req_i.be == can_csr_pkg::BE_HIGH
      |=> {ie_r, sie_r, eie_r, cce_r} ==
          $past({ie_r, sie_r, eie_r, cce_r}))
      else $error("high byte write changed low byte");

   c_recovery: cover property ($rose(bus_off_flag_r) ##[1:1000] $rose(bus_join_o));
   c_status_irq: cover property (core_evt_i.tx_ok ##1 irq_o);
   c_low_write: cover property (hit && cpu_req_i.be == can_csr_pkg::BE_LOW);

endmodule

// File: verilog/can_csr_pkg.sv
// Constants, types and field layout of the CAN control/status block.
package can_csr_pkg;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam logic [15:0] CSR_ADDR  = 16'hef00;
   localparam logic [7:0]  WIN_PAGE  = 8'hef;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int INIT_BIT = 0;
   localparam int IE_BIT   = 1;
   localparam int SIE_BIT  = 2;
   localparam int EIE_BIT  = 3;
   localparam int CCE_BIT  = 6;
   localparam int TST_BIT  = 7;
   localparam int LEC_LSB  = 8;
   localparam int TX_SUCCESS_FLAG_BIT = 11;
   localparam int RX_SUCCESS_FLAG_BIT = 12;
   localparam int ERROR_WARNING_FLAG_BIT = 14;
   localparam int BUS_OFF_FLAG_BIT = 15;

   // ---------------------------------------------------------------
   // Values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RST      = 8'h01;
   localparam logic [2:0] LEC_NONE      = 3'h0;
   localparam logic [2:0] LEC_BIT0      = 3'h5;
   localparam logic [2:0] LEC_PROBE     = 3'h7;
   localparam logic [3:0] RECESSIVE_RUN = 4'hb;
   localparam logic [1:0] BE_LOW        = 2'h1;
   localparam logic [1:0] BE_HIGH       = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  be;
      logic [15:0] addr;
      logic [15:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic       tx_ok;
      logic       rx_ok;
      logic       err_valid;
      logic [2:0] err_code;
      logic       bus_off;
      logic       err_warn;
      logic       bit_tick;
   } core_evt_t;

   typedef enum logic [1:0] {REC_HOLD, REC_WAIT, REC_RUN} rec_state_t;

endpackage

// File: test/can_node_model.sv
// Behavioural model of the remote CAN nodes seen through a transceiver.
`timescale 1ns/1ps
module can_node_model (
   input  wire logic                   sys_clk_i,
   input  wire logic                   dominant_i,
   input  wire can_csr_pkg::core_evt_t evt_i,
   output can_csr_pkg::core_evt_t      evt_o,
   output logic                        can_rxd_o
);
   logic [2:0] tick_cnt_r = 3'h0;
   logic [2:0] tick_cnt_nxt;

   // One bit time is eight clocks, so a level change settles before a tick.
   always_comb
   begin
      tick_cnt_nxt = tick_cnt_r + 3'h1;
      evt_o = evt_i;
      evt_o.bit_tick = (tick_cnt_r == 3'h7);
   end

   always_ff @(posedge sys_clk_i)
   begin
      tick_cnt_r <= tick_cnt_nxt;
   end

   assign can_rxd_o = ~dominant_i;
endmodule

// File: test/testbench.sv
// Self-checking bench for the CAN control/status block.
`timescale 1ns/1ps
module testbench;
   logic                   sys_clk;
   logic                   rst;
   logic                   dom;
   logic                   rxd;
   logic                   ack;
   logic                   bus_join;
   logic                   unlock;
   logic                   tmode;
   logic                   irq;
   logic [15:0]            rdata;
   can_csr_pkg::cpu_req_t  req;
   can_csr_pkg::core_evt_t ev;
   can_csr_pkg::core_evt_t evt;
   int                     n_mismatch = 0;
   int                     n_checks = 0;

   can_node_model u_node (.sys_clk_i(sys_clk), .dominant_i(dom), .evt_i(ev),
      .evt_o(evt), .can_rxd_o(rxd));

   can_control_status_init u_dut (.sys_clk_i(sys_clk), .rst_i(rst),
      .cpu_req_i(req), .core_evt_i(evt), .can_rxd_i(rxd),
      .cpu_rdata_o(rdata), .cpu_ack_o(ack), .bus_join_o(bus_join),
      .timing_wr_unlock_o(unlock), .test_mode_o(tmode), .irq_o(irq));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] s,
                      input logic [15:0] e);
      n_checks++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask

   task automatic xfer(input logic w, input logic [1:0] be,
                       input logic [15:0] a, input logic [15:0] d,
                       input logic ea, input logic [15:0] er);
      @(posedge sys_clk);
      req <= '{wr: w, rd: !w, be: be, addr: a, wdata: d};
      @(posedge sys_clk);
      req <= '0;
      #1;
      chk("ack", {15'h0, ack}, {15'h0, ea});
      if (!w)
         chk("rdata", rdata, er);
   endtask

   // Pulses are cleared after one cycle; levels are left standing.
   task automatic pulse(input can_csr_pkg::core_evt_t e, input logic ei);
      @(posedge sys_clk);
      ev <= e;
      @(posedge sys_clk);
      ev.tx_ok <= 1'b0;
      ev.rx_ok <= 1'b0;
      ev.err_valid <= 1'b0;
      #1;
      chk("irq", {15'h0, irq}, {15'h0, ei});
   endtask

   task automatic join_wait(input int exp);
      int n;
      n = 0;
      // Recovery counting starts one clock after the clear has landed.
      @(posedge sys_clk);
      for (int i = 0; i < 300 && bus_join !== 1'b1; i++)
      begin
         @(posedge sys_clk);
         if (evt.bit_tick === 1'b1 && bus_join !== 1'b1)
            n++;
      end
      chk("ticks", n[15:0], exp[15:0]);
   endtask

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   initial
   begin
      repeat (3000) @(posedge sys_clk);
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      req = '0;
      ev = '0;
      dom = 1'b1;
      rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h0001);
      chk("join", {15'h0, bus_join}, 16'h0000);
      done("reset");
      xfer(1'b1, 2'h1, 16'hef00, 16'hff0e, 1'b1, 16'h0000);
      repeat (40) @(posedge sys_clk);
      chk("join", {15'h0, bus_join}, 16'h0000);
      chk("unlock", {15'h0, unlock}, 16'h0000);
      for (int i = 0; i < 9 && evt.bit_tick !== 1'b1; i++)
         @(posedge sys_clk);
      dom <= 1'b0;
      join_wait(11);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h000e);
      done("recovery");
      xfer(1'b1, 2'h2, 16'hef00, 16'h0700, 1'b1, 16'h0000);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h070e);
      pulse('{tx_ok: 1'b1, default: '0}, 1'b1);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h080e);
      pulse('{err_valid: 1'b1, err_code: 3'h3, default: '0}, 1'b1);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h0b0e);
      xfer(1'b1, 2'h1, 16'hef00, 16'h000c, 1'b1, 16'h0000);
      pulse('{tx_ok: 1'b1, default: '0}, 1'b0);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h080c);
      xfer(1'b1, 2'h2, 16'hef00, 16'h0000, 1'b1, 16'h0000);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h000c);
      done("status");
      xfer(1'b1, 2'h1, 16'hef00, 16'h004e, 1'b1, 16'h0000);
      chk("unlock", {15'h0, unlock}, 16'h0001);
      chk("test", {15'h0, tmode}, 16'h0000);
      pulse('{bus_off: 1'b1, err_warn: 1'b1, default: '0}, 1'b1);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'hc04f);
      chk("join", {15'h0, bus_join}, 16'h0000);
      xfer(1'b1, 2'h1, 16'hef00, 16'h004e, 1'b1, 16'h0000);
      join_wait(11);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'hc54e);
      xfer(1'b1, 2'h1, 16'hef00, 16'h0046, 1'b1, 16'h0000);
      pulse('0, 1'b0);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h0546);
      pulse('{rx_ok: 1'b1, default: '0}, 1'b1);
      xfer(1'b0, 2'h3, 16'hef00, 16'h0000, 1'b1, 16'h1046);
      done("bus_off");
      xfer(1'b0, 2'h3, 16'hef02, 16'h0000, 1'b1, 16'h0000);
      xfer(1'b0, 2'h3, 16'hee00, 16'h0000, 1'b0, 16'h0000);
      done("window");
      report_and_stop();
   end
endmodule
